// [common/swd_defines.svh]
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH
`define SWD_PORT_INDEX   1'b0
`define SWD_PORT_DATA    1'b1
`define SWD_UNLOCK_KEY   8'h87
`define SWD_LOCK_KEY     8'hAA
`define SWD_IDX_LDSEL    8'h07
`define SWD_IDX_PINFN    8'h2D
`define SWD_IDX_ACT      8'h30
`define SWD_IDX_UNIT     8'hF5
`define SWD_IDX_COUNT    8'hF6
`define SWD_LDN_WDOG     8'h08
`define SWD_UNIT_MIN_BIT 3
`define SWD_CLK_HZ       25000000
`define SWD_SEC_PER_MIN  60
`define SWD_RST_PULSE    16
`endif

// [common/swd_pkg.sv]
package swd_pkg;
    typedef enum logic [1:0] {
        SWD_LOCKED  = 2'b00,
        SWD_HALF    = 2'b01,
        SWD_OPEN    = 2'b10
    } swd_cfg_t;
endpackage : swd_pkg

// [core/swd_tick_div.sv]
`timescale 1ns/100ps
`include "swd_defines.svh"
module swd_tick_div
    import swd_pkg::*;
#(
    parameter int DIV = `SWD_CLK_HZ
)
(
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic restart,
    output logic      tick
);
    typedef struct packed
    {
        logic [31:0] cnt;
        logic        tick;
    } swd_div_st_t;
    swd_div_st_t s_q;
    swd_div_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        // restart aligns the first unit to the load moment
        if (restart)
        begin
            s_d.cnt = '0;
        end
        else if (s_q.cnt == 32'(DIV - 1))
        begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : swd_tick_div

// [core/swd_watchdog.sv]
`timescale 1ns/100ps
`include "swd_defines.svh"
module swd_watchdog
    import swd_pkg::*;
#(
    parameter int TICK_DIV    = `SWD_CLK_HZ,
    parameter int SEC_PER_MIN = `SWD_SEC_PER_MIN,
    parameter int RST_CYCLES  = `SWD_RST_PULSE
)
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic       io_addr,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    output logic            sys_reset_out,
    output logic            wdog_running
);
    typedef struct packed
    {
        swd_cfg_t    cfg;
        logic [7:0]  index;
        logic [7:0]  ldsel;
        logic [7:0]  pinfn;
        logic [7:0]  act;
        logic [7:0]  unit;
        logic [7:0]  count;
        logic [7:0]  remain;
        logic [5:0]  sub;
        logic [7:0]  rdata;
        logic [7:0]  rst_cnt;
        logic        rst_out;
        logic        running;
    } swd_state_t;

    swd_state_t s_q;
    swd_state_t s_d;
    logic       tick;
    logic       load;
    logic       ld_match;
    logic [7:0] rd_mux;

    // one-second time base, realigned whenever a count is loaded
    swd_tick_div #(
        .DIV     (TICK_DIV)
    ) u_div (
        .clk_sys (clk_sys),
        .srst    (srst),
        .restart (load),
        .tick    (tick)
    );

    assign ld_match = (s_q.ldsel == `SWD_LDN_WDOG);
    assign load = io_wr && io_addr == `SWD_PORT_DATA
        && s_q.cfg == SWD_OPEN && ld_match
        && s_q.index == `SWD_IDX_COUNT;

    always_comb
    begin
        rd_mux = 8'h00;
        if (s_q.index == `SWD_IDX_LDSEL)
        begin
            rd_mux = s_q.ldsel;
        end
        else if (ld_match)
        begin
            unique case (s_q.index)
                `SWD_IDX_PINFN: rd_mux = s_q.pinfn;
                `SWD_IDX_ACT:   rd_mux = s_q.act;
                `SWD_IDX_UNIT:  rd_mux = s_q.unit;
                `SWD_IDX_COUNT: rd_mux = s_q.remain;
                default:        rd_mux = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        s_d = s_q;
        // index port: unlock sequence, then plain index writes
        if (io_wr && io_addr == `SWD_PORT_INDEX)
        begin
            unique case (s_q.cfg)
                SWD_LOCKED:
                    s_d.cfg = (io_wdata == `SWD_UNLOCK_KEY) ? SWD_HALF
                        : SWD_LOCKED;
                SWD_HALF:
                    s_d.cfg = (io_wdata == `SWD_UNLOCK_KEY) ? SWD_OPEN
                        : SWD_LOCKED;
                SWD_OPEN:
                begin
                    if (io_wdata == `SWD_LOCK_KEY)
                    begin
                        s_d.cfg = SWD_LOCKED;
                    end
                    else
                    begin
                        s_d.index = io_wdata;
                    end
                end
                default:
                    s_d.cfg = SWD_LOCKED;
            endcase
        end
        // data port writes; locked device ignores them
        if (io_wr && io_addr == `SWD_PORT_DATA && s_q.cfg == SWD_OPEN)
        begin
            if (s_q.index == `SWD_IDX_LDSEL)
            begin
                s_d.ldsel = io_wdata;
            end
            else if (ld_match)
            begin
                unique case (s_q.index)
                    `SWD_IDX_PINFN: s_d.pinfn = io_wdata;
                    `SWD_IDX_ACT:   s_d.act = io_wdata;
                    `SWD_IDX_UNIT:  s_d.unit = io_wdata;
                    `SWD_IDX_COUNT:
                    begin
                        s_d.count = io_wdata;
                        s_d.remain = io_wdata;
                        s_d.sub = '0;
                    end
                    default: ;
                endcase
            end
        end
        if (io_rd)
        begin
            s_d.rdata = (io_addr == `SWD_PORT_INDEX) ? s_q.index : rd_mux;
            // locked device hides its data port
            if (io_addr == `SWD_PORT_DATA && s_q.cfg != SWD_OPEN)
            begin
                s_d.rdata = 8'h00;
            end
        end
        // counting: only when active and a nonzero count was loaded
        if (!s_d.act[0])
        begin
            s_d.remain = 8'h00;
            s_d.sub = '0;
        end
        else if (!load && tick && s_q.remain != 8'h00)
        begin
            // minute unit steps the count once per 60 ticks
            if (s_q.unit[`SWD_UNIT_MIN_BIT]
                && s_q.sub != 6'(SEC_PER_MIN - 1))
            begin
                s_d.sub = s_q.sub + 6'h01;
            end
            else
            begin
                s_d.sub = '0;
                s_d.remain = s_q.remain - 8'h01;
                if (s_q.remain == 8'h01)
                begin
                    s_d.rst_cnt = 8'(RST_CYCLES);
                end
            end
        end
        // reset pulse is stretched so the board reset logic catches it
        if (s_q.rst_cnt != 8'h00)
        begin
            s_d.rst_cnt = s_q.rst_cnt - 8'h01;
        end
        s_d.rst_out = s_d.rst_cnt != 8'h00;
        // status follows the count after this cycle's step
        s_d.running = s_d.act[0] && s_d.remain != 8'h00;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign io_rdata = s_q.rdata;
    assign sys_reset_out = s_q.rst_out;
    assign wdog_running = s_q.running;
endmodule : swd_watchdog

// [verification/swd_watchdog_assertions.sv]
`timescale 1ns/100ps
module swd_watchdog_chk
#(
    parameter int TICK_DIV    = 10,
    parameter int SEC_PER_MIN = 3,
    parameter int RST_CYCLES  = 16
)
(
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       io_wr,
    input wire logic       io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       sys_reset_out,
    input wire logic       wdog_running
);
    // slack of a few cycles: divider restart phase is the designer's
    localparam int SLO = TICK_DIV - 1;
    localparam int SHI = TICK_DIV + 3;
    localparam int MLO = TICK_DIV * SEC_PER_MIN - 1;
    localparam int MHI = TICK_DIV * SEC_PER_MIN + 4;
    logic [7:0] idx_q;
    logic       min_q;
    wire        cw = io_wr && io_addr && idx_q == 8'hf6;
    wire        aw = io_wr && io_addr && idx_q == 8'h30;
    always_ff @(posedge clk_sys)
    begin
        if (io_wr && !io_addr)
            idx_q <= io_wdata;
        if (io_wr && io_addr && idx_q == 8'hf5)
            min_q <= io_wdata[3];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_sec; cw && io_wdata == 8'h01 && !min_q; endsequence
    sequence s_min; cw && io_wdata == 8'h01 && min_q; endsequence
    sequence s_fire; $rose(sys_reset_out); endsequence
    a_zero_off: assert property (cw && io_wdata == 8'h00 |=> !wdog_running)
        else $error("zero count runs");
    a_load_run: assert property (cw && io_wdata != 8'h00 |=> wdog_running)
        else $error("load not running");
    a_stop_now: assert property (aw && io_wdata == 8'h00 |=> !wdog_running)
        else $error("stop ignored");
    a_sec_expiry: assert property (s_sec |-> ##[SLO:SHI] s_fire)
        else $error("second expiry off");
    a_min_expiry: assert property (s_min |-> ##[MLO:MHI] s_fire)
        else $error("minute expiry off");
    a_no_early: assert property (cw |=> !sys_reset_out [*8])
        else $error("reset soon after kick");
    a_pulse_end: assert property (s_fire |-> ##RST_CYCLES !sys_reset_out)
        else $error("pulse length off");
    a_reset_cause: assert property (s_fire |-> $past(wdog_running, 3))
        else $error("reset without countdown");
endmodule : swd_watchdog_chk
bind swd_watchdog swd_watchdog_chk #(.TICK_DIV(TICK_DIV),
    .SEC_PER_MIN(SEC_PER_MIN), .RST_CYCLES(RST_CYCLES)) u_chk (
    .clk_sys(clk_sys), .srst(srst), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .sys_reset_out(sys_reset_out),
    .wdog_running(wdog_running));

// [verification/system_watchdog_reset_timer_tb.sv]
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module system_watchdog_reset_timer_tb;
    logic       clk_sys = 1'b0, srst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
    logic       io_addr = 1'b0, rd_q = 1'b0, sys_reset_out, wdog_running;
    logic [7:0] io_wdata = 8'h00, v, e_v, io_rdata;
    logic [7:0] exp_q[$];
    int         n_errors = 0, compares = 0, cyc = 0;
    swd_watchdog #(.TICK_DIV(10), .SEC_PER_MIN(3), .RST_CYCLES(16)) dut (
        .clk_sys(clk_sys), .srst(srst), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .sys_reset_out(sys_reset_out), .wdog_running(wdog_running));
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        rd_q <= io_rd;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    // read data is registered, so compare one cycle after the strobe
    always @(negedge clk_sys)
        if (rd_q)
        begin
            e_v = exp_q.pop_front();
            `CHK("rdata", e_v, io_rdata)
        end
    task automatic wr(input logic a, input logic [7:0] d);
        @(negedge clk_sys);
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge clk_sys);
        io_wr = 1'b0;
    endtask : wr
    task automatic cfg(input logic [7:0] i, input logic [7:0] d);
        wr(1'b0, i);
        wr(1'b1, d);
    endtask : cfg
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        wr(1'b0, i);
        @(negedge clk_sys);
        io_rd = 1'b1;
        io_addr = 1'b1;
        exp_q.push_back(e);
        @(negedge clk_sys);
        io_rd = 1'b0;
    endtask : rd
    task automatic expire(input int lo, input int hi);
        int k;
        k = 0;
        while (sys_reset_out !== 1'b1 && k < 200)
        begin
            @(negedge clk_sys);
            k++;
        end
        `CHK("expiry", 1'b1, k >= lo && k <= hi)
        k = 0;
        while (sys_reset_out === 1'b1 && k < 40)
        begin
            @(negedge clk_sys);
            k++;
        end
        `CHK("pulse", 16, k)
    endtask : expire
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        void'($urandom(24));
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        wr(1'b0, 8'h87);
        wr(1'b0, 8'h87);
        cfg(8'h07, 8'h08);
        cfg(8'h30, 8'h01);
        cfg(8'hf5, 8'h00);
        rd(8'hf5, 8'h00);
        v = 8'($urandom_range(2, 255));
        cfg(8'hf6, v);
        rd(8'hf6, v);
        cfg(8'hf6, 8'h00);
        repeat (40) @(negedge clk_sys);
        `CHK("zero", 1'b0, sys_reset_out | wdog_running)
        for (int i = 0; i < 5; i++)
        begin
            cfg(8'hf6, 8'h02);
            repeat (12) @(negedge clk_sys);
            `CHK("kick", 1'b0, sys_reset_out)
        end
        cfg(8'hf6, 8'h01);
        expire(9, 13);
        cfg(8'hf5, 8'h08);
        rd(8'hf5, 8'h08);
        cfg(8'hf6, 8'h01);
        expire(29, 34);
        cfg(8'hf6, 8'h05);
        cfg(8'h30, 8'h00);
        @(negedge clk_sys);
        `CHK("stop", 1'b0, wdog_running)
        rd(8'hf6, 8'h00);
        // relocked device reads 00 on its data port
        wr(1'b0, 8'haa);
        rd(8'hf5, 8'h00);
        wr(1'b0, 8'h87);
        wr(1'b0, 8'h87);
        rd(8'hf5, 8'h08);
        repeat (2) @(negedge clk_sys);
        print_verdict();
    end
endmodule : system_watchdog_reset_timer_tb
